// ---- design/eps_consts.svh ----
// Shared constants of the host serial port, device end and host end.
`ifndef EPS_CONSTS_SVH
`define EPS_CONSTS_SVH
`define EPS_CLK_NS        40
`define EPS_SCK_NS        320
`define EPS_HALF_CYC      (`EPS_SCK_NS / `EPS_CLK_NS / 2)
`define EPS_BYTE_BITS     4'h8
`define EPS_FRAME3_BITS   4'h9
`define EPS_CS_GAP_NS     250
`define EPS_CS_GAP_CYC    ((`EPS_CS_GAP_NS + `EPS_CLK_NS - 1) / `EPS_CLK_NS)
`endif

// ---- design/eps_pkg.sv ----
// Types used by the host end of the host serial port.
`default_nettype none
package eps_pkg;
    typedef enum logic [2:0] {
        EPS_H_IDLE  = 3'b000,
        EPS_H_SETUP = 3'b001,
        EPS_H_LOW   = 3'b010,
        EPS_H_HIGH  = 3'b011,
        EPS_H_GAP   = 3'b100
    } eps_host_state_t;
endpackage
`default_nettype wire

// ---- design/eps_link_if.sv ----
// Serial link between the host and the display controller port.
`default_nettype none
interface eps_link_if;
    logic cs_n;
    logic sck;
    logic dc;
    logic sda_host_o;
    logic sda_host_oe_n;
    logic sda_dev_o;
    logic sda_dev_oe_n;
    logic hw_reset_n;
    logic busy;
    logic bus_mode_strap;
    logic sda;
    assign sda = !sda_host_oe_n ? sda_host_o : (!sda_dev_oe_n ? sda_dev_o : 1'b1);
    modport device (input cs_n, sck, dc, sda, hw_reset_n, bus_mode_strap,
                    output sda_dev_o, sda_dev_oe_n, busy);
    modport host (input sda, busy,
                  output cs_n, sck, dc, sda_host_o, sda_host_oe_n, hw_reset_n,
                  bus_mode_strap);
endinterface
`default_nettype wire

// ---- design/eps_sync.sv ----
// Two-stage synchroniser for a bundle of pin levels.
`default_nettype none
module eps_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk_i,
    input  wire logic         reset_n_i,
    input  wire logic         clk_en_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_ff;
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            meta_ff <= '0;
            sync_o  <= '0;
        end else if (clk_en_i) begin
            meta_ff <= async_i;
            sync_o  <= meta_ff;
        end
    end
endmodule
`default_nettype wire

// ---- design/eps_device.sv ----
// Device end: serial receiver, read shifter and busy output of the controller port.
`include "eps_consts.svh"
`default_nettype none
module eps_device (
    // Clock, reset, enable
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic clk_en_i,
    // Link
    eps_link_if.device link,
    // Received bytes
    output logic       cmd_valid_o,
    output logic       data_valid_o,
    output logic [7:0] rx_byte_o,
    // Read data supply, taken at each read byte start
    input  wire logic [7:0] rd_byte_i,
    output logic       rd_req_o,
    // Internal activity for busy
    input  wire logic  waveform_active_i,
    input  wire logic  sensor_active_i,
    // Hardware reset as seen by the core
    output logic       core_reset_n_o
);
    logic [5:0] pins_s;
    logic       cs_n_s, sck_s, dc_s, sda_s, hrst_s, strap_s;
    logic       sck_d_ff, cs_n_d_ff, mode3_ff, reading_ff, rd_armed_ff, skip_ff;
    logic [3:0] bit_cnt_ff;
    logic [8:0] shift_ff;
    logic [7:0] tx_ff;
    logic [2:0] tx_cnt_ff;
    logic       rise, fall, sel, last_bit;
    logic [8:0] nxt_shift;

    eps_sync #(.W(6)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clk_en_i   (clk_en_i),
        .async_i    ({link.cs_n, link.sck, link.dc, link.sda, link.hw_reset_n,
                      link.bus_mode_strap}),
        .sync_o     (pins_s)
    );
    assign {cs_n_s, sck_s, dc_s, sda_s, hrst_s, strap_s} = pins_s;

    assign sel      = !cs_n_s;
    assign rise     = sel && sck_s && !sck_d_ff;
    assign fall     = sel && !sck_s && sck_d_ff;
    assign last_bit = bit_cnt_ff == (mode3_ff ? `EPS_FRAME3_BITS : `EPS_BYTE_BITS) - 4'h1;
    assign nxt_shift = {shift_ff[7:0], sda_s};
    assign core_reset_n_o = hrst_s;

    // Kind of a completed byte: in three-wire mode only the in-band flag counts.
    function automatic logic frame_is_data(input logic three_wire, input logic flag,
                                           input logic dc_level);
        frame_is_data = three_wire ? flag : dc_level;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            sck_d_ff  <= 1'b0;
            cs_n_d_ff <= 1'b1;
            mode3_ff  <= 1'b0;
        end else if (clk_en_i) begin
            sck_d_ff  <= sck_s;
            cs_n_d_ff <= cs_n_s;
            // The strap is caught at each frame start so it never changes mid-byte.
            if (cs_n_d_ff && !cs_n_s) begin
                mode3_ff <= strap_s;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive path; a read starts after a command byte when the
    // host flips data/command high (four-wire) or sends a leading flag of one (three-wire).
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || !hrst_s) begin
            bit_cnt_ff   <= 4'h0;
            shift_ff     <= 9'h000;
            rx_byte_o    <= 8'h00;
            cmd_valid_o  <= 1'b0;
            data_valid_o <= 1'b0;
            rd_armed_ff  <= 1'b0;
        end else if (clk_en_i) begin
            cmd_valid_o  <= 1'b0;
            data_valid_o <= 1'b0;
            if (cs_n_s) begin
                bit_cnt_ff  <= 4'h0;
                rd_armed_ff <= 1'b0;
            end else if (rise && !reading_ff) begin
                shift_ff <= nxt_shift;
                if (last_bit) begin
                    bit_cnt_ff <= 4'h0;
                    rx_byte_o    <= nxt_shift[7:0];
                    data_valid_o <= frame_is_data(mode3_ff, shift_ff[7], dc_s);
                    cmd_valid_o  <= !frame_is_data(mode3_ff, shift_ff[7], dc_s);
                    // Only a command byte may be followed by a read phase.
                    rd_armed_ff  <= !frame_is_data(mode3_ff, shift_ff[7], dc_s);
                end else begin
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: four-wire enters read when DC rises after a command byte;
    // three-wire enters it on the rising edge of a lone flag bit of one following a command.
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || !hrst_s) begin
            reading_ff <= 1'b0;
            skip_ff    <= 1'b0;
            tx_ff      <= 8'h00;
            tx_cnt_ff  <= 3'h0;
            rd_req_o   <= 1'b0;
        end else if (clk_en_i) begin
            rd_req_o <= 1'b0;
            if (cs_n_s) begin
                reading_ff <= 1'b0;
                skip_ff    <= 1'b0;
            end else if (!reading_ff) begin
                if (!mode3_ff && rd_armed_ff && dc_s && bit_cnt_ff == 4'h0) begin
                    reading_ff <= 1'b1;
                    skip_ff    <= 1'b0;
                    tx_ff      <= rd_byte_i;
                    tx_cnt_ff  <= 3'h0;
                    rd_req_o   <= 1'b1;
                end else if (mode3_ff && rise && bit_cnt_ff == 4'h0 && sda_s && rd_armed_ff
                             && !data_valid_o) begin
                    // The host still drives the flag bit, so the line is taken only
                    // after that bit's falling edge.
                    reading_ff <= 1'b1;
                    skip_ff    <= 1'b1;
                    tx_ff      <= rd_byte_i;
                    tx_cnt_ff  <= 3'h0;
                    rd_req_o   <= 1'b1;
                end
            end else if (fall && skip_ff) begin
                skip_ff <= 1'b0;
            end else if (fall && tx_cnt_ff == 3'h7) begin
                tx_cnt_ff <= 3'h0;
                tx_ff     <= rd_byte_i;
                rd_req_o  <= 1'b1;
            end else if (fall) begin
                tx_ff     <= {tx_ff[6:0], 1'b0};
                tx_cnt_ff <= tx_cnt_ff + 3'h1;
            end
        end
    end

    assign link.sda_dev_o    = tx_ff[7];
    assign link.sda_dev_oe_n = !(reading_ff && sel && !skip_ff);
    assign link.busy         = waveform_active_i || sensor_active_i;
endmodule
`default_nettype wire

// ---- design/eps_host.sv ----
// Host end: serial master that writes command/data bytes and reads result bytes.
`include "eps_consts.svh"
`default_nettype none
module eps_host (
    // Clock, reset, enable
    input  wire logic core_clk_i,
    input  wire logic reset_n_i,
    input  wire logic clk_en_i,
    // Link
    eps_link_if.host link,
    // User side
    input  wire logic       mode3_i,
    input  wire logic       hw_reset_n_i,
    input  wire logic       req_i,
    input  wire logic       is_data_i,
    input  wire logic [7:0] byte_i,
    input  wire logic [3:0] rd_count_i,
    output logic            ready_o,
    output logic            rd_valid_o,
    output logic [7:0]      rd_byte_o,
    output logic            done_o
);
    eps_pkg::eps_host_state_t state_ff;
    logic       busy_s;
    logic [1:0] sda_s;
    logic [3:0] bit_ff, phase_ff;
    logic [3:0] rd_left_ff;
    logic [7:0] rx_ff;
    logic [8:0] tx_ff;
    logic [3:0] len_ff;
    logic [7:0] tmr_ff;
    logic       rd_phase_ff, dc_ff, cs_n_ff, sck_ff;

    eps_sync #(.W(2)) u_sync (
        .core_clk_i (core_clk_i),
        .reset_n_i  (reset_n_i),
        .clk_en_i   (clk_en_i),
        .async_i    ({link.busy, link.sda}),
        .sync_o     (sda_s)
    );
    assign busy_s = sda_s[1];

    assign ready_o = state_ff == eps_pkg::EPS_H_IDLE && !busy_s;
    assign link.cs_n           = cs_n_ff;
    assign link.sck            = sck_ff;
    assign link.dc             = mode3_i ? 1'b0 : dc_ff;
    assign link.sda_host_o     = tx_ff[8];
    assign link.sda_host_oe_n  = cs_n_ff || rd_phase_ff;
    assign link.hw_reset_n     = hw_reset_n_i;
    assign link.bus_mode_strap = mode3_i;

    ////////////////////////////////////////////////////////////////////////////
    // One byte per request; a nonzero read count turns the frame into a read.
    // The link clock is the core clock divided by 8 (320 ns), within both limits.
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state_ff    <= eps_pkg::EPS_H_IDLE;
            cs_n_ff     <= 1'b1;
            sck_ff      <= 1'b0;
            dc_ff       <= 1'b0;
            tx_ff       <= 9'h000;
            bit_ff      <= 4'h0;
            len_ff      <= 4'h0;
            tmr_ff      <= 8'h00;
            rd_left_ff  <= 4'h0;
            rd_phase_ff <= 1'b0;
            rx_ff       <= 8'h00;
            rd_valid_o  <= 1'b0;
            rd_byte_o   <= 8'h00;
            done_o      <= 1'b0;
            phase_ff    <= 4'h0;
        end else if (clk_en_i) begin
            rd_valid_o <= 1'b0;
            done_o     <= 1'b0;
            tmr_ff     <= tmr_ff + 8'h01;
            case (state_ff)
                eps_pkg::EPS_H_IDLE: begin
                    if (req_i && !busy_s) begin
                        cs_n_ff    <= 1'b0;
                        dc_ff      <= is_data_i && rd_count_i == 4'h0;
                        tx_ff      <= mode3_i ? {is_data_i && rd_count_i == 4'h0, byte_i}
                                              : {byte_i, 1'b0};
                        len_ff     <= mode3_i ? `EPS_FRAME3_BITS : `EPS_BYTE_BITS;
                        rd_left_ff <= rd_count_i;
                        bit_ff     <= 4'h0;
                        tmr_ff     <= 8'h00;
                        state_ff   <= eps_pkg::EPS_H_SETUP;
                    end
                end
                eps_pkg::EPS_H_SETUP: begin
                    if (tmr_ff == 8'(`EPS_HALF_CYC - 1)) begin
                        tmr_ff   <= 8'h00;
                        state_ff <= eps_pkg::EPS_H_LOW;
                    end
                end
                eps_pkg::EPS_H_LOW: begin
                    // Data/command rises one cycle after the last command bit's fall.
                    if (rd_phase_ff) begin
                        dc_ff <= 1'b1;
                    end
                    if (tmr_ff == 8'(`EPS_HALF_CYC - 1)) begin
                        tmr_ff   <= 8'h00;
                        sck_ff   <= 1'b1;
                        state_ff <= eps_pkg::EPS_H_HIGH;
                    end
                end
                eps_pkg::EPS_H_HIGH: begin
                    if (tmr_ff == 8'(`EPS_HALF_CYC - 1)) begin
                        tmr_ff <= 8'h00;
                        sck_ff <= 1'b0;
                        bit_ff <= bit_ff + 4'h1;
                        // Read data is taken at the falling edge: with the synchroniser lag a
                        // sample at the rising edge would still see the previous bit.
                        if (rd_phase_ff) begin
                            rx_ff <= {rx_ff[6:0], sda_s[0]};
                        end else begin
                            tx_ff <= {tx_ff[7:0], 1'b0};
                        end
                        state_ff <= eps_pkg::EPS_H_LOW;
                        if (bit_ff == len_ff - 4'h1) begin
                            bit_ff <= 4'h0;
                            if (rd_phase_ff) begin
                                rd_valid_o <= 1'b1;
                                rd_byte_o  <= {rx_ff[6:0], sda_s[0]};
                                rd_left_ff <= rd_left_ff - 4'h1;
                                if (rd_left_ff == 4'h1) begin
                                    state_ff <= eps_pkg::EPS_H_GAP;
                                end
                            end else if (rd_left_ff != 4'h0) begin
                                // Switch to reading after the falling edge of the last bit.
                                if (mode3_i) begin
                                    tx_ff  <= 9'h100;
                                    len_ff <= 4'h1;
                                    phase_ff <= 4'h1;
                                end else begin
                                    rd_phase_ff <= 1'b1;
                                    len_ff      <= `EPS_BYTE_BITS;
                                end
                            end else begin
                                state_ff <= eps_pkg::EPS_H_GAP;
                            end
                            if (phase_ff == 4'h1) begin
                                phase_ff    <= 4'h0;
                                rd_phase_ff <= 1'b1;
                                len_ff      <= `EPS_BYTE_BITS;
                            end
                        end
                    end
                end
                eps_pkg::EPS_H_GAP: begin
                    cs_n_ff     <= 1'b1;
                    rd_phase_ff <= 1'b0;
                    if (tmr_ff >= 8'(`EPS_CS_GAP_CYC)) begin
                        done_o   <= 1'b1;
                        state_ff <= eps_pkg::EPS_H_IDLE;
                    end
                end
                default: state_ff <= eps_pkg::EPS_H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- testbench/eps_link_monitor.sv ----
// Protocol checker for the serial link between the host end and the device end.
`default_nettype none
module eps_link_monitor (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    // Link
    input wire logic cs_n,
    input wire logic sck,
    input wire logic dc,
    input wire logic sda_host_oe_n,
    input wire logic sda_dev_o,
    input wire logic sda_dev_oe_n,
    input wire logic busy,
    input wire logic bus_mode_strap
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);
    ////////////////////////////////////////////////////////////////////////////
    // Serial clock rises seen inside the current frame; cleared while deselected.
    logic       sck_ff;
    logic [7:0] bits_ff;
    always_ff @(posedge core_clk_i) begin
        sck_ff <= reset_n_i ? sck : 1'b0;
    end
    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i || cs_n) begin
            bits_ff <= 8'h00;
        end else if (sck && !sck_ff) begin
            bits_ff <= bits_ff + 8'h01;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    property p_busy_block;
        $fell(cs_n) |-> !($past(busy) && $past(busy, 2) && $past(busy, 3));
    endproperty
    a_busy_block: assert property (p_busy_block) else $error("frame started while busy");
    property p_dc_steady;
        !cs_n && !bus_mode_strap && $changed(dc) |-> !sck && !$past(sck);
    endproperty
    a_dc_steady: assert property (p_dc_steady) else $error("dc moved with clock high");
    property p_read_dc;
        !cs_n && $past(!cs_n) && !bus_mode_strap && $rose(dc) |-> bits_ff == 8'h08;
    endproperty
    a_read_dc: assert property (p_read_dc) else $error("dc rose before eight bits");
    property p_dc_tied;
        !cs_n && bus_mode_strap |-> !dc;
    endproperty
    a_dc_tied: assert property (p_dc_tied) else $error("dc pin not low in three-wire mode");
    property p_frame_len;
        $rose(cs_n) |-> (bus_mode_strap ?
            (bits_ff == 8'h09 || (bits_ff >= 8'h12 && bits_ff[2:0] == 3'h2)) :
            (bits_ff != 8'h00 && bits_ff[2:0] == 3'h0));
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame bit count wrong");
    property p_dev_release;
        $rose(cs_n) |-> ##[0:4] sda_dev_oe_n;
    endproperty
    a_dev_release: assert property (p_dev_release) else $error("device kept data line");
    property p_no_clash;
        sda_host_oe_n || sda_dev_oe_n;
    endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data line");
    property p_sda_fall;
        !sda_dev_oe_n && $past(!sda_dev_oe_n) && $changed(sda_dev_o) |-> !sck;
    endproperty
    a_sda_fall: assert property (p_sda_fall) else $error("read data moved with clock high");
    property p_sck_still;
        cs_n && $past(cs_n) |-> $stable(sck);
    endproperty
    a_sck_still: assert property (p_sck_still) else $error("clock ran while deselected");
    c_read4: cover property (!cs_n && !bus_mode_strap && $rose(dc) && bits_ff == 8'h08);
    c_frame3: cover property ($rose(cs_n) && bus_mode_strap);
    c_busy: cover property (busy && cs_n);
endmodule
`default_nettype wire

// ---- testbench/epaper_host_serial_port_tb.sv ----
// Bench joining host end and device end, plus a second device driven by hand.
`default_nettype none
module epaper_host_serial_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic       core_clk_i = 1'b0;
    logic       reset_n_i = 1'b0;
    logic       en = 1'b1, mode3 = 1'b0, hw_rst_n = 1'b1, req = 1'b0, is_data = 1'b0;
    logic       wave = 1'b0, sens = 1'b0;
    logic [7:0] byte_v = 8'h00, rd_idx = 8'h00, rd_byte, rd_data, rx_b, rx_b2, rd_base;
    logic [3:0] rd_cnt = 4'h0;
    logic       ready, rd_valid, done, cmd_v, data_v, rd_req, core_rst_n, cmd_v2, data_v2;
    logic [8:0] rxq[$], rxq2[$];
    logic [7:0] rdq[$];
    logic [7:0] pat[4] = '{8'h81, 8'h7e, 8'h01, 8'hfe};
    int         mismatches = 0, comparisons = 0, hits;
    eps_link_if link();
    eps_link_if link2();
    always #20 core_clk_i = ~core_clk_i;
    assign rd_byte = 8'hc3 + rd_idx * 8'h25;
    eps_host i_eps_host (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
        .link(link.host), .mode3_i(mode3), .hw_reset_n_i(hw_rst_n), .req_i(req),
        .is_data_i(is_data), .byte_i(byte_v), .rd_count_i(rd_cnt), .ready_o(ready),
        .rd_valid_o(rd_valid), .rd_byte_o(rd_data), .done_o(done));
    eps_device i_eps_device (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
        .link(link.device), .cmd_valid_o(cmd_v), .data_valid_o(data_v), .rx_byte_o(rx_b),
        .rd_byte_i(rd_byte), .rd_req_o(rd_req), .waveform_active_i(wave),
        .sensor_active_i(sens), .core_reset_n_o(core_rst_n));
    eps_device i_eps_device_b (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .clk_en_i(en),
        .link(link2.device), .cmd_valid_o(cmd_v2), .data_valid_o(data_v2), .rx_byte_o(rx_b2),
        .rd_byte_i(rd_byte), .rd_req_o(), .waveform_active_i(wave),
        .sensor_active_i(sens), .core_reset_n_o());
    eps_link_monitor i_eps_link_monitor (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
        .cs_n(link.cs_n), .sck(link.sck), .dc(link.dc), .sda_host_oe_n(link.sda_host_oe_n),
        .sda_dev_o(link.sda_dev_o), .sda_dev_oe_n(link.sda_dev_oe_n), .busy(link.busy),
        .bus_mode_strap(link.bus_mode_strap));
    ////////////////////////////////////////////////////////////////////////////
    always @(posedge core_clk_i) begin
        if (cmd_v === 1'b1) rxq.push_back({1'b0, rx_b});
        if (data_v === 1'b1) rxq.push_back({1'b1, rx_b});
        if (cmd_v2 === 1'b1) rxq2.push_back({1'b0, rx_b2});
        if (data_v2 === 1'b1) rxq2.push_back({1'b1, rx_b2});
        if (rd_req === 1'b1) rd_idx <= rd_idx + 8'h01;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic chk_bit(input string what, input logic exp, input logic got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic pop_rx(input bit second, input logic [8:0] exp);
        logic [8:0] got;
        if (second) got = rxq2.size() > 0 ? rxq2.pop_front() : 'x;
        else got = rxq.size() > 0 ? rxq.pop_front() : 'x;
        chk_byte("received byte", exp[7:0], got[7:0]);
        chk_bit("received kind", exp[8], got[8]);
    endtask
    // One frame from the host end; requests wait for ready, so busy is honoured.
    task automatic xfer(input logic m, input logic d, input logic [7:0] b, input logic [3:0] n);
        int k;
        mode3 = m;
        is_data = d;
        byte_v = b;
        rd_cnt = n;
        req = 1'b1;
        for (k = 0; k < 400 && ready !== 1'b1; k++) tick(1);
        tick(1);
        req = 1'b0;
        for (k = 0; k < 600 && done !== 1'b1; k++) begin
            tick(1);
            if (rd_valid === 1'b1) rdq.push_back(rd_data);
        end
        chk_bit("frame done", 1'b1, done);
        tick(12);
    endtask
    // Hand-driven frame on the second link at the bench's 320 ns serial clock.
    task automatic bb(input logic csv, input logic dcp, input logic strap, input logic [8:0] v,
                      input int n);
        int i;
        link2.bus_mode_strap = strap;
        link2.dc = dcp;
        tick(4);
        link2.cs_n = csv;
        for (i = n - 1; i >= 0; i--) begin
            link2.sda_host_o = v[i];
            tick(4);
            link2.sck = 1'b1;
            tick(4);
            link2.sck = 1'b0;
        end
        tick(4);
        link2.cs_n = 1'b1;
        link2.sda_host_o = ~link2.sda_host_o;
        tick(12);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        link2.cs_n = 1'b1;
        link2.sck = 1'b0;
        link2.dc = 1'b0;
        link2.sda_host_o = 1'b1;
        link2.sda_host_oe_n = 1'b0;
        link2.hw_reset_n = 1'b1;
        link2.bus_mode_strap = 1'b0;
        repeat (3) @(posedge core_clk_i);
        #1;
        reset_n_i = 1'b1;
        tick(3);
        for (int m = 0; m < 2; m++) begin
            for (int d = 0; d < 2; d++) begin
                xfer(m[0], d[0], pat[m * 2 + d], 4'h0);
                pop_rx(1'b0, {d[0], pat[m * 2 + d]});
            end
        end
        $display("write test finished");
        for (int m = 0; m < 2; m++) begin
            rd_base = rd_idx * 8'h25;
            xfer(m[0], 1'b0, 8'h2f, 4'h2);
            pop_rx(1'b0, {1'b0, 8'h2f});
            chk_byte("read count", 8'h02, 8'(rdq.size()));
            chk_byte("read first", 8'hc3 + rd_base, rdq.size() > 0 ? rdq.pop_front() : 'x);
            chk_byte("read second", 8'he8 + rd_base, rdq.size() > 0 ? rdq.pop_front() : 'x);
        end
        $display("read test finished");
        wave = 1'b1;
        tick(3);
        chk_bit("busy from waveform", 1'b1, link.busy);
        chk_bit("ready while busy", 1'b0, ready);
        hits = 0;
        fork
            xfer(1'b0, 1'b1, 8'h5c, 4'h0);
            begin
                repeat (30) begin
                    tick(1);
                    if (link.cs_n !== 1'b1) hits++;
                end
                wave = 1'b0;
            end
        join
        chk_byte("select while busy", 8'h00, 8'(hits));
        pop_rx(1'b0, {1'b1, 8'h5c});
        sens = 1'b1;
        tick(1);
        chk_bit("busy from sensor", 1'b1, link.busy);
        sens = 1'b0;
        tick(1);
        chk_bit("busy idle", 1'b0, link.busy);
        hw_rst_n = 1'b0;
        tick(5);
        chk_bit("core reset held", 1'b0, core_rst_n);
        hw_rst_n = 1'b1;
        tick(5);
        chk_bit("core reset released", 1'b1, core_rst_n);
        $display("busy and reset test finished");
        bb(1'b1, 1'b0, 1'b0, 9'h0ff, 8);
        chk_byte("bytes while deselected", 8'h00, 8'(rxq2.size()));
        bb(1'b0, 1'b1, 1'b0, 9'h01f, 5);
        bb(1'b0, 1'b1, 1'b0, 9'h096, 8);
        pop_rx(1'b1, {1'b1, 8'h96});
        chk_byte("partial byte dropped", 8'h00, 8'(rxq2.size()));
        bb(1'b0, 1'b1, 1'b1, 9'h02d, 9);
        pop_rx(1'b1, {1'b0, 8'h2d});
        bb(1'b0, 1'b0, 1'b1, 9'h1a4, 9);
        pop_rx(1'b1, {1'b1, 8'ha4});
        $display("second link test finished");
        report_and_stop;
    end
    initial begin
        repeat (20000) @(posedge core_clk_i);
        mismatches++;
        report_and_stop;
    end
endmodule
`default_nettype wire
